// file: design/svwd_cfg.svh
// Timing, offset and field constants of the supervisor watchdog block.
`ifndef SVWD_CFG_SVH
`define SVWD_CFG_SVH
// ****************************************************************
// Clock and derived cycle counts
// ****************************************************************
`define SVWD_CLK_NS        10
`define SVWD_GLITCH_NS     50
`define SVWD_GLITCH_CYC    ((`SVWD_GLITCH_NS + `SVWD_CLK_NS - 1) / `SVWD_CLK_NS)
`define SVWD_MD_NS         500
`define SVWD_MD_CYC        ((`SVWD_MD_NS + `SVWD_CLK_NS - 1) / `SVWD_CLK_NS)
`define SVWD_LR_NS         500
`define SVWD_LR_CYC        (`SVWD_LR_NS / `SVWD_CLK_NS)
`define SVWD_TICK_US       500
`define SVWD_TICK_CYC      (`SVWD_TICK_US * 1000 / `SVWD_CLK_NS)
`define SVWD_MS2TK(ms)     ((ms) * 1000 / `SVWD_TICK_US)
// ****************************************************************
// Delays in milliseconds
// ****************************************************************
`define SVWD_POR0_MS       50
`define SVWD_POR1_MS       200
`define SVWD_POR2_MS       400
`define SVWD_POR3_MS       800
`define SVWD_WDT0_MS       1400
`define SVWD_WDT1_MS       200
`define SVWD_WDT2_MS       25
`define SVWD_RST_LONG_MS   200
`define SVWD_RST_SHORT_MS  25
`define SVWD_NV_MS         5
// ****************************************************************
// Register map and fields
// ****************************************************************
`define SVWD_CTRL_OFS      8'h00
`define SVWD_STAT_OFS      8'h04
`define SVWD_CTRL_POR_LSB  0
`define SVWD_CTRL_WDT_LSB  2
`define SVWD_STAT_RST_BIT  0
`define SVWD_STAT_WDO_BIT  1
`define SVWD_STAT_NV_BIT   2
`define SVWD_STAT_LOW_BIT  3
`define SVWD_POR_SEL_RST   2'h1
`define SVWD_WDT_SEL_RST   2'h3
`define SVWD_WDT_OFF       2'h3
`define SVWD_WDT_SHORT     2'h2
`define SVWD_RESP_OKAY     2'h0
`define SVWD_RESP_SLVERR   2'h2
// ****************************************************************
// Two-wire frame decode
// ****************************************************************
`define SVWD_RW_BIT        5'h07
`define SVWD_WR_MIN_BITS   5'h12
`define SVWD_BIT_MAX       5'h1F
`endif

// file: design/svwd_pkg.sv
// Types shared by the supervisor watchdog modules.
package svwd_pkg;
  typedef logic [11:0] svwd_tick_t;

  typedef struct packed {
    logic [1:0] wdt_sel;
    logic [1:0] por_sel;
  } svwd_ctrl_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic       q;
  } svwd_filt_s;

  typedef struct packed {
    svwd_ctrl_s  ctrl;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        scl_q;
    logic        sda_q;
    logic        in_frame;
    logic [4:0]  bit_cnt;
    logic        is_write;
    logic [19:0] tick_cnt;
    svwd_tick_t  por_cnt;
    logic [5:0]  mr_cnt;
    logic        mr_rst;
    logic [5:0]  pd_cnt;
    logic        pd_rst;
    logic        warn_n;
    logic        rst_n;
    svwd_tick_t  wd_cnt;
    svwd_tick_t  wdo_cnt;
    logic        wdo_act;
    svwd_tick_t  nv_cnt;
    logic        nv_busy;
  } svwd_state_s;
endpackage : svwd_pkg

// file: design/svwd_glitch.sv
// Input pulse suppressor: passes a level only after it has held steady.
`timescale 1ns/100ps
`default_nettype none
`include "svwd_cfg.svh"
module svwd_glitch
  import svwd_pkg::*;
#(
  parameter int STABLE = `SVWD_GLITCH_CYC
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Raw level, reset level and filtered level
  input  wire logic din,
  input  wire logic rst_val,
  output logic      dout
);
  svwd_filt_s s;
  svwd_filt_s next_s;

  if (STABLE < 1 || STABLE > 255) begin : g_chk
    $error("svwd_glitch: STABLE out of range");
  end

  // A change must persist STABLE cycles; shorter pulses never reach dout.
  always_comb begin
    next_s = s;
    if (din == s.q) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt == 8'(STABLE - 1)) begin
      next_s.q   = din; // [R6]
      next_s.cnt = 8'h00;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  // Resetting to the pin's idle level keeps a false edge from reaching the bus watcher.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{cnt: 8'h00, q: rst_val};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.q;

  a_glitch_reject: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    $changed(s.q) && $past(aresetn) |-> $past(din, STABLE) == s.q && $past(din, 1) == s.q)
    else $error("filtered level changed without a steady input");
endmodule : svwd_glitch
`default_nettype wire

// file: design/svwd_top.sv
// Supervisor watchdog timing: power-on reset, watchdog, manual reset, write cycle.
//
// Overview of operation
// [R1] The power-on reset delay is 50, 200 (default), 400 or 800 ms for setting 00, 01, 10, 11.
// [R2] The watchdog period is 1.4 s, 200 ms or 25 ms for 00, 01, 10; 11 turns it off (default).
// [R3] The watchdog output stays low 25 ms for the 25 ms period and 200 ms for the others.
// [R4] A stop ending a write sequence starts a self-timed write that ends within 10 ms, about 5.
// [R5] The host waits out the write cycle or polls before starting another write.
// [R6] Pulses narrower than 50 ns on the bus inputs are ignored.
// [R7] The host holds each watchdog restart for at least 1 us.
// [R8] Manual reset asserts the reset output no sooner than 500 ns; release is immediate.
// [R9] On power-down the low-supply warning goes low about 500 ns before reset.
// [R10] A start followed by a stop on the bus restarts the watchdog with the selected period.
// [R11] When the period elapses the watchdog output goes low for the timeout, then releases.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "svwd_cfg.svh"
module svwd_top
  import svwd_pkg::*;
#(
  parameter int TICK_CYCLES = `SVWD_TICK_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Two-wire bus, watched only
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // Supervisor pins
  input  wire logic        manual_reset_in,
  input  wire logic        supply_low_in,
  output logic             reset_out_n,
  output logic             low_supply_warn_n,
  output logic             wdt_timeout_out_n,
  output logic             nv_write_busy
);
  // ****************************************************************
  // Delay selection
  // ****************************************************************
  function automatic svwd_tick_t por_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    por_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_POR0_MS));
      2'h1:    por_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_POR1_MS));
      2'h2:    por_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_POR2_MS));
      default: por_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_POR3_MS));
    endcase
  endfunction : por_ticks

  function automatic svwd_tick_t wdt_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    wdt_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_WDT0_MS));
      2'h1:    wdt_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_WDT1_MS));
      default: wdt_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_WDT2_MS));
    endcase
  endfunction : wdt_ticks

  // Only the nominal timeout is produced, well inside its tolerance band.
  function automatic svwd_tick_t wdo_ticks(input logic [1:0] sel);
    if (sel == `SVWD_WDT_SHORT) begin
      wdo_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_RST_SHORT_MS));
    end else begin
      wdo_ticks = svwd_tick_t'(`SVWD_MS2TK(`SVWD_RST_LONG_MS));
    end
  endfunction : wdo_ticks

  if (TICK_CYCLES < 2 || TICK_CYCLES > 1048576) begin : g_chk
    $error("svwd_top: TICK_CYCLES out of range");
  end

  localparam svwd_state_s RST_S = '{
    ctrl:    '{wdt_sel: `SVWD_WDT_SEL_RST, por_sel: `SVWD_POR_SEL_RST},
    por_cnt: svwd_tick_t'(`SVWD_MS2TK(`SVWD_POR1_MS)),
    warn_n:  1'b1,
    scl_q:   1'b1,
    sda_q:   1'b1,
    wd_cnt:  svwd_tick_t'(`SVWD_MS2TK(`SVWD_WDT2_MS)),
    default: '0
  };

  svwd_state_s s;
  svwd_state_s next_s;
  logic [2:0]  raw;
  logic [2:0]  filt;
  logic        scl_f;
  logic        sda_f;
  logic        mr_f;
  logic        tick;
  logic        start_c;
  logic        stop_c;
  logic        restart;
  logic        wd_en;

  // ****************************************************************
  // Input filters
  // ****************************************************************
  assign raw = {manual_reset_in, sda_in, scl_in};
  // The bus lines idle high and the manual reset input idles low.
  for (genvar i = 0; i < 3; i++) begin : g_filt
    svwd_glitch #(.STABLE(`SVWD_GLITCH_CYC)) u_filt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (raw[i]),
      .rst_val ((i == 2) ? 1'b0 : 1'b1),
      .dout    (filt[i])
    );
  end
  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign mr_f  = filt[2];

  assign tick    = (s.tick_cnt == 20'(TICK_CYCLES - 1));
  assign start_c = scl_f && s.scl_q && s.sda_q && !sda_f;
  assign stop_c  = scl_f && s.scl_q && !s.sda_q && sda_f;
  assign restart = stop_c && s.in_frame;
  assign wd_en   = (s.ctrl.wdt_sel != `SVWD_WDT_OFF);

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.tick_cnt = tick ? 20'h00000 : s.tick_cnt + 20'h00001;
    // Register bus: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `SVWD_RESP_OKAY;
      if (s.awaddr == `SVWD_CTRL_OFS) begin
        if (s.wstrb0) begin
          next_s.ctrl.por_sel = s.wdata[`SVWD_CTRL_POR_LSB +: 2];
          next_s.ctrl.wdt_sel = s.wdata[`SVWD_CTRL_WDT_LSB +: 2];
        end
      end else if (s.awaddr != `SVWD_STAT_OFS) begin
        next_s.bresp = `SVWD_RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = 32'h00000000;
      next_s.rresp  = `SVWD_RESP_OKAY;
      if (s_axi_araddr == `SVWD_CTRL_OFS) begin
        next_s.rdata[`SVWD_CTRL_POR_LSB +: 2] = s.ctrl.por_sel;
        next_s.rdata[`SVWD_CTRL_WDT_LSB +: 2] = s.ctrl.wdt_sel;
      end else if (s_axi_araddr == `SVWD_STAT_OFS) begin
        next_s.rdata[`SVWD_STAT_RST_BIT] = !s.rst_n;
        next_s.rdata[`SVWD_STAT_WDO_BIT] = s.wdo_act;
        next_s.rdata[`SVWD_STAT_NV_BIT]  = s.nv_busy;
        next_s.rdata[`SVWD_STAT_LOW_BIT] = !s.warn_n;
      end else begin
        next_s.rresp = `SVWD_RESP_SLVERR;
      end
    end
    // Bus watcher: start, stop and the read/write bit of the first byte.
    next_s.scl_q = scl_f;
    next_s.sda_q = sda_f;
    if (start_c) begin
      next_s.in_frame = 1'b1;
      next_s.bit_cnt  = 5'h00;
      next_s.is_write = 1'b0;
    end else if (stop_c) begin
      next_s.in_frame = 1'b0;
    end else if (s.in_frame && scl_f && !s.scl_q) begin
      if (s.bit_cnt != `SVWD_BIT_MAX) begin
        next_s.bit_cnt = s.bit_cnt + 5'h01;
      end
      if (s.bit_cnt == `SVWD_RW_BIT) begin
        next_s.is_write = !sda_f;
      end
    end
    // Self-timed write; a stop while busy starts nothing new.
    if (restart && s.is_write && s.bit_cnt >= `SVWD_WR_MIN_BITS && !s.nv_busy) begin
      next_s.nv_busy = 1'b1; // [R4]
      next_s.nv_cnt  = svwd_tick_t'(`SVWD_MS2TK(`SVWD_NV_MS));
    end else if (s.nv_busy && tick) begin
      next_s.nv_cnt = s.nv_cnt - 12'h001;
      if (s.nv_cnt == 12'h001) begin
        next_s.nv_busy = 1'b0;
      end
    end
    // Manual reset: delayed on activation, released at once.
    if (mr_f) begin
      if (!s.mr_rst) begin
        if (s.mr_cnt == 6'(`SVWD_MD_CYC - 1)) begin
          next_s.mr_rst = 1'b1; // [R8]
        end else begin
          next_s.mr_cnt = s.mr_cnt + 6'h01;
        end
      end
    end else begin
      next_s.mr_cnt = 6'h00;
      next_s.mr_rst = 1'b0; // [R8]
    end
    // Power-down: warning first, reset after the warning lead.
    next_s.warn_n = !supply_low_in; // [R9]
    if (!s.warn_n) begin
      if (!s.pd_rst) begin
        if (s.pd_cnt == 6'(`SVWD_LR_CYC - 1)) begin
          next_s.pd_rst = 1'b1; // [R9]
        end else begin
          next_s.pd_cnt = s.pd_cnt + 6'h01;
        end
      end
    end else begin
      next_s.pd_cnt = 6'h00;
      next_s.pd_rst = 1'b0;
    end
    // Power-on delay reloads while the power-down reset is held and runs once the supply is back.
    if (s.pd_rst) begin
      next_s.por_cnt = por_ticks(s.ctrl.por_sel); // [R1]
    end else if (tick && s.por_cnt != 12'h000) begin
      next_s.por_cnt = s.por_cnt - 12'h001;
    end
    next_s.rst_n = !(next_s.por_cnt != 12'h000 || next_s.mr_rst || next_s.pd_rst);
    // Watchdog: held reloaded while off or while the system is in reset.
    if (!wd_en || !s.rst_n) begin
      next_s.wd_cnt  = wdt_ticks(s.ctrl.wdt_sel); // [R2]
      next_s.wdo_act = 1'b0;
      next_s.wdo_cnt = 12'h000;
    end else if (s.wdo_act) begin
      if (tick) begin
        next_s.wdo_cnt = s.wdo_cnt - 12'h001;
        if (s.wdo_cnt == 12'h001) begin
          next_s.wdo_act = 1'b0; // [R11]
          next_s.wd_cnt  = wdt_ticks(s.ctrl.wdt_sel);
        end
      end
    end else if (restart) begin
      next_s.wd_cnt = wdt_ticks(s.ctrl.wdt_sel); // [R10]
    end else if (tick) begin
      if (s.wd_cnt <= 12'h001) begin
        next_s.wdo_act = 1'b1; // [R11]
        next_s.wdo_cnt = wdo_ticks(s.ctrl.wdt_sel); // [R3]
      end else begin
        next_s.wd_cnt = s.wd_cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_bresp       = s.bresp;
  assign s_axi_bvalid      = s.bvalid;
  assign s_axi_rdata       = s.rdata;
  assign s_axi_rresp       = s.rresp;
  assign s_axi_rvalid      = s.rvalid;
  assign reset_out_n       = s.rst_n;
  assign low_supply_warn_n = s.warn_n;
  assign wdt_timeout_out_n = !s.wdo_act;
  assign nv_write_busy     = s.nv_busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_por_reload: assert property ($fell(s.pd_rst) |-> // [R1]
    s.por_cnt == por_ticks($past(s.ctrl.por_sel)) && !reset_out_n)
    else $error("power-on delay not reloaded from the selection");
  a_wdt_off: assert property (s.ctrl.wdt_sel == `SVWD_WDT_OFF |=> wdt_timeout_out_n) // [R2]
    else $error("watchdog output active while disabled");
  a_wdo_load: assert property ($rose(s.wdo_act) |-> // [R3]
    s.wdo_cnt == wdo_ticks($past(s.ctrl.wdt_sel)))
    else $error("watchdog timeout length wrong");
  a_nv_start: assert property ($rose(s.nv_busy) |-> // [R4]
    s.nv_cnt == svwd_tick_t'(`SVWD_MS2TK(`SVWD_NV_MS)) && $past(restart))
    else $error("write cycle started wrongly");
  a_mr_delay: assert property ($rose(s.mr_rst) |-> $past(mr_f, `SVWD_MD_CYC)) // [R8]
    else $error("manual reset asserted too early");
  a_mr_release: assert property ($fell(mr_f) |=> !s.mr_rst ##1 !s.mr_rst) // [R8]
    else $error("manual reset not released at once");
  a_warn_first: assert property ($rose(s.pd_rst) |-> // [R9]
    !$past(s.warn_n, `SVWD_LR_CYC) && $past(s.warn_n, `SVWD_LR_CYC + 1))
    else $error("reset did not follow warning by the lead time");
  a_restart_reload: assert property (restart && wd_en && s.rst_n && !s.wdo_act |=> // [R10]
    s.wd_cnt == wdt_ticks($past(s.ctrl.wdt_sel)) && wdt_timeout_out_n)
    else $error("restart did not reload the watchdog");
  a_wdo_end: assert property (s.wdo_act && tick && s.wdo_cnt == 12'h001 |=> // [R11]
    wdt_timeout_out_n)
    else $error("watchdog output not released after timeout");

  c_wdt_fire: cover property ($rose(s.wdo_act));
  c_nv_write: cover property ($fell(s.nv_busy));
  c_mr_reset: cover property ($rose(s.mr_rst));
  c_power_down: cover property ($rose(s.pd_rst) ##[1:100] $fell(s.pd_rst));
endmodule : svwd_top
`default_nettype wire

// file: verification/svwd_host.sv
// Host model on the two-wire bus: watchdog restarts, write frames and glitches.
`timescale 1ns/100ps
`default_nettype none
module svwd_host (
  // Clock
  input  wire logic aclk,
  // Bus lines, driven high by the host when idle
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask : hold

  // A start held for 1 us, then a stop, with the clock line left high.
  task automatic restart();
    @(posedge aclk);
    sda <= 1'b0;
    hold(100);
    sda <= 1'b1;
    hold(1);
  endtask : restart

  // A dip of 3 cycles, shorter than the 5-cycle filter span, must not read as a start.
  task automatic glitch();
    @(posedge aclk);
    sda <= 1'b0;
    hold(3);
    sda <= 1'b1;
    hold(1);
  endtask : glitch

  // Address byte with the write flag low, a data byte, then a stop.
  task automatic write_frame();
    @(posedge aclk);
    sda <= 1'b0;
    hold(60);
    for (int i = 0; i < 19; i++) begin
      scl <= 1'b0;
      hold(30);
      sda <= (i == 7) ? 1'b0 : (i % 3 != 0);
      hold(100);
      scl <= 1'b1;
      hold(130);
    end
    scl <= 1'b0;
    hold(30);
    sda <= 1'b0;
    hold(100);
    scl <= 1'b1;
    hold(60);
    sda <= 1'b1;
    hold(1);
  endtask : write_frame
endmodule : svwd_host
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench of the supervisor watchdog timing block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import svwd_pkg::*;
  // Short tick keeps every millisecond figure within a brief run.
  localparam int TK = 4;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, scl, sda, mr, low;
  logic        rst_n, warn_n, wdo_n, busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rng, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          error_cnt, cmp_count, cyc, n, t0;
  int          por_tk[4] = '{100, 400, 800, 1600};
  int          wdt_tk[3] = '{2800, 400, 50};
  int          out_tk[3] = '{400, 400, 50};

  svwd_top #(.TICK_CYCLES(TK)) i_svwd_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl), .sda_in(sda), .manual_reset_in(mr), .supply_low_in(low),
    .reset_out_n(rst_n), .low_supply_warn_n(warn_n), .wdt_timeout_out_n(wdo_n),
    .nv_write_busy(busy)
  );
  svwd_host i_svwd_host (.aclk(aclk), .scl(scl), .sda(sda));

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  always @(negedge aclk) cyc++;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic sig(input int k);
    case (k)
      0: return rst_n;
      1: return warn_n;
      2: return wdo_n;
      default: return busy;
    endcase
  endfunction : sig

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic near(input string nm, input int seen, input int exp, input int tol);
    check(nm, (seen >= exp - tol && seen <= exp + tol) ? exp : seen, exp);
  endtask : near

  // Counts falling edges until the chosen output shows the level, or the limit.
  task automatic wait_lvl(input int k, input logic v, input int lim, output int c);
    c = 0;
    while (sig(k) !== v && c < lim) begin
      @(negedge aclk);
      c++;
    end
  endtask : wait_lvl

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, done;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (done !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, done;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (done !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Whole run is about 40k cycles; twice that means a hang.
  initial begin
    #800000;
    error_cnt++;
    finish_test();
  end

  initial begin
    rng = 32'h0000317D;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mr, low} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check("reset_out", rst_n, 1'b0);
    check("wdt_out", wdo_n, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b1;
    wait_lvl(0, 1'b1, 3000, n);
    near("por_default", n, por_tk[1] * TK, 8);
    axi_rd(8'h00, rd, rsp);
    check("ctrl_reset", rd, 32'h0000000D);
    axi_rd(8'h08, rd, rsp);
    check("unmapped_rd", {rd[29:0], rsp}, 32'h2);
    axi_wr(8'h08, xs(), rsp);
    check("unmapped_wr", 32'(rsp), 32'h2);
    axi_wr(8'h04, xs(), rsp);
    check("status_wr", 32'(rsp), 32'h0);
    wstrb <= 4'hE;
    axi_wr(8'h00, xs(), rsp);
    wstrb <= 4'hF;
    axi_rd(8'h00, rd, rsp);
    check("ctrl_no_strobe", rd, 32'h0000000D);
    @(posedge aclk);
    mr <= 1'b1;
    repeat (3) @(posedge aclk);
    mr <= 1'b0;
    wait_lvl(0, 1'b0, 70, n);
    check("mr_glitch", n, 70);
    @(posedge aclk);
    mr <= 1'b1;
    wait_lvl(0, 1'b0, 100, n);
    check("mr_min", 32'(n >= 50), 32'h1);
    near("mr_delay", n, 56, 2);
    @(posedge aclk);
    mr <= 1'b0;
    wait_lvl(0, 1'b1, 20, n);
    near("mr_release", n, 6, 3);
    for (int p = 0; p < 4; p++) begin
      rd = xs();
      axi_wr(8'h00, {rd[31:4], 2'h3, 2'(p)}, rsp);
      axi_rd(8'h00, rd, rsp);
      check("ctrl_por", rd, {28'h0, 2'h3, 2'(p)});
      @(posedge aclk);
      low <= 1'b1;
      wait_lvl(1, 1'b0, 10, n);
      check("warn_first", {n < 10, rst_n}, 32'h3);
      wait_lvl(0, 1'b0, 100, n);
      near("warn_to_reset", n, 50, 1);
      axi_rd(8'h04, rd, rsp);
      check("status_low", rd, 32'h00000009);
      @(posedge aclk);
      low <= 1'b0;
      wait_lvl(0, 1'b1, 7000, n);
      near("por_sel", n, por_tk[p] * TK, 8);
    end
    for (int s = 0; s < 3; s++) begin
      rd = xs();
      axi_wr(8'h00, {rd[31:4], 2'(s), 2'h1}, rsp);
      i_svwd_host.restart();
      if (s == 2) begin
        repeat (3) begin
          repeat (40) @(posedge aclk);
          i_svwd_host.restart();
        end
      end
      t0 = cyc;
      if (s == 2) begin
        repeat (150) @(posedge aclk);
        i_svwd_host.glitch();
      end
      wait_lvl(2, 1'b0, 12000, n);
      near("wdt_period", cyc - t0, wdt_tk[s] * TK + 6, 12);
      // The status read takes two cycles out of the measured low time.
      axi_rd(8'h04, rd, rsp);
      check("status_wdt", rd, 32'h00000002);
      wait_lvl(2, 1'b1, 2000, n);
      near("wdt_timeout", n, out_tk[s] * TK - 2, 8);
    end
    axi_wr(8'h00, 32'h0000000D, rsp);
    i_svwd_host.restart();
    wait_lvl(2, 1'b0, 3000, n);
    check("wdt_off", n, 3000);
    i_svwd_host.write_frame();
    wait_lvl(3, 1'b1, 20, n);
    t0 = cyc;
    check("busy_start", 32'(n < 20), 32'h1);
    axi_rd(8'h04, rd, rsp);
    check("status_busy", rd, 32'h00000004);
    wait_lvl(3, 1'b0, 200, n);
    near("write_cycle", cyc - t0, 38, 4);
    finish_test();
  end
endmodule : tb
`default_nettype wire
